/* rtl/irq_ctrl_map.svh */
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

`define PRIO_SEL_ADDR      8'hf9
`define REQ_LATCH_ADDR     8'hfa
`define ENABLE_MASK_ADDR   8'hfb

`define PRIO_GROUP_C_BIT   0
`define PRIO_GROUP_LO_BIT  1
`define PRIO_GROUP_MID_BIT 3
`define PRIO_GROUP_HI_BIT  4
`define PRIO_GROUP_B_BIT   2
`define PRIO_GROUP_A_BIT   5

`define REQ_EDGE_LO_BIT    6
`define REQ_EDGE_HI_BIT    7

`define MASK_RAMPROT_BIT   6
`define MASK_GLOBAL_BIT    7

`define PRIO_SEL_RESET     8'h00
`define REQ_LATCH_RESET    8'h00
`define ENABLE_MASK_RESET  8'h00

`define NUM_SOURCES        6

`endif

/* rtl/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

	typedef enum logic [2:0] {
		ORDER_RSVD0 = 3'h0,
		ORDER_CAB   = 3'h1,
		ORDER_ACB   = 3'h2,
		ORDER_ABC   = 3'h3,
		ORDER_BCA   = 3'h4,
		ORDER_CBA   = 3'h5,
		ORDER_RSVD6 = 3'h6,
		ORDER_RSVD7 = 3'h7
	} group_order_type;

	typedef logic [5:0] src_vec_type;

endpackage

/* rtl/irq_src_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface irq_src_if;
	logic [5:0] raw;
	logic [5:0] event_pulse;
	logic [1:0] edge_sel;

	modport capture (input raw, input edge_sel, output event_pulse);
	modport owner (output raw, output edge_sel, input event_pulse);
endinterface

`default_nettype wire

/* rtl/irq_src_capture.sv */
`timescale 1ns/1ns
`default_nettype none

module irq_src_capture
	import irq_ctrl_pkg::*;
(
	input  wire logic   mclk,
	input  wire logic   nrst,
	irq_src_if.capture  src
);

	logic [5:0] sync1_ff;
	logic [5:0] sync2_ff;
	logic [5:0] sync3_ff;
	logic [5:0] stable_ff;
	logic [5:0] rise;
	logic [5:0] fall;
	logic [5:0] use_rise;

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// Pins idle high, timers low: no false edge after reset
			sync1_ff  <= 6'h0f;
			sync2_ff  <= 6'h0f;
			sync3_ff  <= 6'h0f;
			stable_ff <= 6'h0f;
		end else begin
			sync1_ff <= src.raw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			stable_ff <= (sync2_ff & sync3_ff) | (stable_ff & (sync2_ff | sync3_ff));
		end
	end

	// Bit 0 is pin two, bit 2 is pin one; timers always rise, pins zero/three fall
	assign use_rise = {2'b00, 1'b0, src.edge_sel[1], 1'b0, src.edge_sel[0]};

	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_edge
			assign rise[i] = (sync2_ff[i] & sync3_ff[i]) & ~stable_ff[i];
			assign fall[i] = ~(sync2_ff[i] | sync3_ff[i]) & stable_ff[i];
			assign src.event_pulse[i] = (i >= 4) ? rise[i] : (use_rise[i] ? rise[i] : fall[i]);
		end
	endgenerate

endmodule

`default_nettype wire

/* rtl/irq_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_map.svh"

module irq_ctrl
	import irq_ctrl_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       port3_pin_zero,
	input  wire logic       port3_pin_one,
	input  wire logic       port3_pin_two,
	input  wire logic       port3_pin_three,
	input  wire logic       timer_zero,
	input  wire logic       timer_one,
	input  wire logic       ram_protect_option,
	output logic            irq_pending,
	output logic      [2:0] irq_vector,
	output logic            ram_protect_active
);

	logic [7:0]      prio_ff;
	logic [7:0]      req_ff;
	logic [7:0]      mask_ff;
	logic            option_ff;
	logic            nxt_pending;
	logic [2:0]      nxt_vector;
	src_vec_type     active;
	group_order_type order;
	logic            pick_c;
	logic            pick_b;
	logic            pick_a;

	// Capture module owns synchronisers and edge detection
	irq_src_if src ();

	// Source order fixes request bit positions
	assign src.raw = {timer_one, timer_zero, port3_pin_zero,
		port3_pin_one, port3_pin_three, port3_pin_two};
	// Edge pick lives in request register bits 7:6
	assign src.edge_sel = req_ff[`REQ_EDGE_HI_BIT:`REQ_EDGE_LO_BIT];

	irq_src_capture u_capture (
		.mclk (mclk),
		.nrst (nrst),
		.src  (src)
	);

	// Write-only; bits 7:6 are stored but have no function
	// Reserved order codes park the outputs, not the last winner
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prio_ff <= `PRIO_SEL_RESET;
		end else if (reg_wr && reg_addr == `PRIO_SEL_ADDR) begin
			prio_ff <= reg_wdata;
		end
	end

	// Writing a one sets a bit, so software may raise a request
	// Hardware set beats a simultaneous software clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			req_ff <= `REQ_LATCH_RESET;
		end else if (reg_wr && reg_addr == `REQ_LATCH_ADDR) begin
			req_ff <= reg_wdata | {2'b00, src.event_pulse};
		end else begin
			req_ff <= req_ff | {2'b00, src.event_pulse};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// Bits 5:0 per source, bit 6 RAM protect, bit 7 global
			mask_ff <= `ENABLE_MASK_RESET;
		end else if (reg_wr && reg_addr == `ENABLE_MASK_ADDR) begin
			mask_ff <= reg_wdata;
		end
	end

	// Option strap caught after reset release, not under it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			option_ff <= 1'b0;
		end else begin
			option_ff <= ram_protect_option;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// Without the option strap the enable bit is only storage
			ram_protect_active <= 1'b0;
		end else begin
			ram_protect_active <= option_ff & mask_ff[`MASK_RAMPROT_BIT];
		end
	end

	// Read data holds between reads so a slow core can sample late
	// Priority register is write-only; reads return zero there
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`REQ_LATCH_ADDR:   reg_rdata <= req_ff;
				`ENABLE_MASK_ADDR: reg_rdata <= mask_ff;
				default:           reg_rdata <= 8'h00;
			endcase
		end
	end

	// Only pending, unmasked and globally enabled sources compete
	assign active = req_ff[5:0] & mask_ff[5:0] & {6{mask_ff[`MASK_GLOBAL_BIT]}};
	// Order code sits on bits 4, 3 and 1, around the group B sub bit
	assign order  = group_order_type'({prio_ff[`PRIO_GROUP_HI_BIT],
		prio_ff[`PRIO_GROUP_MID_BIT], prio_ff[`PRIO_GROUP_LO_BIT]});

	// Winner within each group
	// A pick bit high selects source 4 in group C, source 0 in group B, source 3 in group A
	assign pick_c = prio_ff[`PRIO_GROUP_C_BIT] ? active[4] : ~active[1];
	assign pick_b = prio_ff[`PRIO_GROUP_B_BIT] ? active[0] : ~active[2];
	assign pick_a = prio_ff[`PRIO_GROUP_A_BIT] ? active[3] : ~active[5];

	// Flag in bit 3, winning source number in bits 2:0
	function automatic logic [3:0] grp(input logic [1:0] g, input src_vec_type a,
			input logic pc, input logic pb, input logic pa);
		logic [3:0] r;
		r = 4'h0;
		unique case (g)
			2'd0: r = (a[1] | a[4]) ? {1'b1, pc ? 3'd4 : 3'd1} : 4'h0;
			2'd1: r = (a[0] | a[2]) ? {1'b1, pb ? 3'd0 : 3'd2} : 4'h0;
			default: r = (a[3] | a[5]) ? {1'b1, pa ? 3'd3 : 3'd5} : 4'h0;
		endcase
		return r;
	endfunction

	// Group codes: 0 = C, 1 = B, 2 = A
	// Earlier group wins outright; later groups only fill in
	always_comb begin
		logic [3:0] g1;
		logic [3:0] g2;
		logic [3:0] g3;
		g1 = 4'h0;
		g2 = 4'h0;
		g3 = 4'h0;
		unique case (order)
			ORDER_CAB: begin
				g1 = grp(2'd0, active, pick_c, pick_b, pick_a);
				g2 = grp(2'd2, active, pick_c, pick_b, pick_a);
				g3 = grp(2'd1, active, pick_c, pick_b, pick_a);
			end
			ORDER_ACB: begin
				g1 = grp(2'd2, active, pick_c, pick_b, pick_a);
				g2 = grp(2'd0, active, pick_c, pick_b, pick_a);
				g3 = grp(2'd1, active, pick_c, pick_b, pick_a);
			end
			ORDER_ABC: begin
				g1 = grp(2'd2, active, pick_c, pick_b, pick_a);
				g2 = grp(2'd1, active, pick_c, pick_b, pick_a);
				g3 = grp(2'd0, active, pick_c, pick_b, pick_a);
			end
			ORDER_BCA: begin
				g1 = grp(2'd1, active, pick_c, pick_b, pick_a);
				g2 = grp(2'd0, active, pick_c, pick_b, pick_a);
				g3 = grp(2'd2, active, pick_c, pick_b, pick_a);
			end
			ORDER_CBA: begin
				g1 = grp(2'd0, active, pick_c, pick_b, pick_a);
				g2 = grp(2'd1, active, pick_c, pick_b, pick_a);
				g3 = grp(2'd2, active, pick_c, pick_b, pick_a);
			end
			default: begin
				// Reserved codes present nothing; software must not use them
				g1 = 4'h0;
			end
		endcase
		if (g1[3]) begin
			nxt_pending = 1'b1;
			nxt_vector  = g1[2:0];
		end else if (g2[3]) begin
			nxt_pending = 1'b1;
			nxt_vector  = g2[2:0];
		end else begin
			nxt_pending = g3[3];
			nxt_vector  = g3[3] ? g3[2:0] : 3'h0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// Outputs come straight from flops, one edge behind state
			irq_pending <= 1'b0;
			irq_vector  <= 3'h0;
		end else begin
			irq_pending <= nxt_pending;
			irq_vector  <= nxt_vector;
		end
	end

endmodule

`default_nettype wire

/* verif/irq_ctrl_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_chk (
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       ram_protect_option,
	input wire logic       irq_pending,
	input wire logic [2:0] irq_vector,
	input wire logic       ram_protect_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	AST_WO_READ: assert property (reg_rd && reg_addr == 8'hf9 |=> reg_rdata == 8'h00)
		else $error("priority readable");
	AST_UNMAPPED: assert property (reg_rd && reg_addr < 8'hf9 |=> reg_rdata == 8'h00)
		else $error("unmapped read");
	AST_MASK_RW: assert property (reg_wr && reg_addr == 8'hfb ##1 reg_rd && !reg_wr &&
		reg_addr == 8'hfb |=> reg_rdata == $past(reg_wdata, 2))
		else $error("mask readback");
	AST_RAMPROT_OFF: assert property (!ram_protect_option [*3] |-> !ram_protect_active)
		else $error("protect without option");
	AST_GLOBAL_OFF: assert property (reg_wr && reg_addr == 8'hfb && !reg_wdata[7] ##1 !reg_wr
		|=> !irq_pending)
		else $error("pending while disabled");
	AST_MASK_RW_GAP: assert property (reg_wr && reg_addr == 8'hfb ##1 !reg_wr ##1 reg_rd &&
		!reg_wr && reg_addr == 8'hfb |=> reg_rdata == $past(reg_wdata, 3))
		else $error("mask readback after gap");
	AST_RSVD_CODE: assert property (reg_wr && reg_addr == 8'hf9 &&
		{reg_wdata[4], reg_wdata[3], reg_wdata[1]} == 3'h0
		##1 !reg_wr |=> !irq_pending)
		else $error("reserved order pending");
	AST_VEC_RANGE: assert property (irq_vector <= 3'h5)
		else $error("vector range");
	AST_IDLE_VEC: assert property (!irq_pending |-> irq_vector == 3'h0)
		else $error("idle vector");
endmodule
`default_nettype wire

/* verif/event_source.sv */
`timescale 1ns/1ns
`default_nettype none
module event_source (
	input  wire logic       mclk,
	input  wire logic [5:0] tgl,
	output logic      [5:0] pin
);
	// Port pins idle high, timer outputs idle low
	initial pin = 6'h0f;
	always @(posedge mclk) pin <= pin ^ tgl;
endmodule
`default_nettype wire

/* verif/test_six_source_interrupt_controller.sv */
`timescale 1ns/1ns
`default_nettype none
module test_six_source_interrupt_controller;
	logic        mclk, nrst, reg_wr, reg_rd, ram_protect_option;
	logic        irq_pending, ram_protect_active;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [2:0]  irq_vector, b;
	logic [5:0]  tgl, pin;
	logic [17:0] bitmap;
	logic [31:0] tbl [17];
	int          failures, checked, cyc;

	irq_ctrl dut (.*, .port3_pin_zero(pin[0]), .port3_pin_one(pin[1]), .port3_pin_two(pin[2]),
		.port3_pin_three(pin[3]), .timer_zero(pin[4]), .timer_one(pin[5]));
	event_source src (.mclk(mclk), .tgl(tgl), .pin(pin));

	task give_verdict;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e, input string n);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge mclk) #1;
		reg_wr = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge mclk) #1;
		reg_addr = a;
		reg_rd = 1;
		@(posedge mclk) #1;
		reg_rd = 0;
		chk(reg_rdata, e, n);
	endtask
	// Sync plus latch takes four edges, eight leaves margin
	task tog(input logic [5:0] t);
		@(posedge mclk) #1;
		tgl = t;
		@(posedge mclk) #1;
		tgl = 0;
		repeat (8) @(posedge mclk);
		#1;
	endtask

	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			give_verdict;
		end
	end

	initial begin
		{nrst, reg_wr, reg_rd, ram_protect_option, reg_addr, reg_wdata, tgl} = 0;
		bitmap = {3'h5, 3'h4, 3'h1, 3'h0, 3'h2, 3'h3};
		tbl = '{32'hbf26_0211, 32'hbf26_0815, 32'hbf26_0a15, 32'hbf26_1012,
			32'hbf26_1211, 32'hbf26_0000, 32'hbf26_1a00, 32'hbf06_0811,
			32'hbf06_0a12, 32'hbf12_0211, 32'hbf12_0314,
			32'hbf05_0212, 32'hbf05_0610,
			32'hbf28_0215, 32'hbf28_2213,
			32'h3f26_0200, 32'hbd26_0215};
		repeat (5) @(posedge mclk);
		#1 nrst = 1;
		rd(8'hfa, 8'h00, "request");
		rd(8'hfb, 8'h00, "mask");
		rd(8'hf9, 8'h00, "priority");
		rd(8'h10, 8'h00, "unmapped");
		wr(8'hfb, 8'hff);
		rd(8'hfb, 8'hff, "mask");
		chk(ram_protect_active, 8'h00, "protect");
		ram_protect_option = 1;
		repeat (4) @(posedge mclk);
		#1 chk(ram_protect_active, 8'h01, "protect");
		wr(8'hf9, 8'h02);
		for (int s = 0; s < 6; s++) begin
			b = bitmap[s*3+:3];
			tog(6'h01 << s);
			tog(6'h01 << s);
			rd(8'hfa, 8'h01 << b, "source");
			chk(irq_vector, b, "vector");
			wr(8'hfa, 8'h00);
		end
		for (int e = 0; e < 4; e++) begin
			wr(8'hfa, {e[1:0], 6'h00});
			tog(6'h06);
			rd(8'hfa, {e[1:0], 3'h0, ~e[1], 1'h0, ~e[0]}, "falling");
			tog(6'h06);
			rd(8'hfa, {e[1:0], 6'h05}, "rising");
		end
		foreach (tbl[i]) begin
			wr(8'hfb, tbl[i][31:24]);
			wr(8'hf9, tbl[i][15:8]);
			wr(8'hfa, tbl[i][23:16]);
			repeat (2) @(posedge mclk);
			#1 chk(irq_pending, tbl[i][7:4], "pending");
			chk(irq_vector, tbl[i][3:0], "winner");
		end
		give_verdict;
	end
endmodule

bind irq_ctrl irq_ctrl_chk chk_i (.*);
`default_nettype wire
